// [design/tbc_defs.svh]
`ifndef TBC_DEFS_SVH
`define TBC_DEFS_SVH

// Register byte offsets.
`define TBC_OFS_CTRL      8'h00
`define TBC_OFS_IRQ_MASK  8'h0C
`define TBC_OFS_STATUS    8'h10
`define TBC_OFS_EVGEN     8'h14
`define TBC_OFS_CHAN_EN   8'h20
`define TBC_OFS_COUNTER   8'h24
`define TBC_OFS_PRESCALE  8'h28
`define TBC_OFS_RELOAD    8'h2C
`define TBC_OFS_REPEAT    8'h30
`define TBC_OFS_CAPTURE   8'h34
`define TBC_OFS_OUT_CTRL  8'h44

// Control register fields.
`define TBC_CTRL_RUN      0
`define TBC_CTRL_IN_MODE  1
`define TBC_CTRL_CENTER   2
`define TBC_CTRL_ARPE     3

// Channel enable register fields.
`define TBC_CHEN_ENABLE   0
`define TBC_CHEN_COMPL    2

// Output control register fields.
`define TBC_OUT_IDLE_LVL  8
`define TBC_OUT_IDLE_OSS  10
`define TBC_OUT_RUN_OSS   11
`define TBC_OUT_MAIN_EN   15

// Status, mask and event generate fields.
`define TBC_ST_UPDATE     0
`define TBC_ST_CAPTURE    1
`define TBC_EV_UPDATE     0

// Reset values.
`define TBC_RST_RELOAD    16'hFFFF
`define TBC_RST_ZERO16    16'h0000
`define TBC_RST_ZERO8     8'h00

`endif

// [design/tbc_pkg.sv]
package tbc_pkg;

	// Counting direction, one-hot.
	typedef enum logic [1:0]
	{
		TBC_DIR_UP   = 2'b01,
		TBC_DIR_DOWN = 2'b10
	} tbc_dir_t;

	typedef logic [15:0] tbc_word_t;

endpackage

// [design/tbc_top.sv]
// Functional notes
// - Output mode, enable 0: pin follows main enable and off/idle settings.
// - Output mode, enable 1: compare signal reaches pin, qualified by main enable.
// - Input mode: enable bit 1 allows capture, 0 blocks it.
// - Counter ticks at input clock divided by prescaler setting plus one.
// - Prescaler setting becomes active only on update, soft or trigger.
// - Written reload value is transferred to the active reload register.
// - Reload resets to all ones; counter stopped while reload is zero.
// - Repetition setting sets update and update interrupt rate.
// - Repetition down-counter raises update at zero, then restarts from setting.
// - Repetition writes take effect only at the next update, repetition, soft or trigger.
// - Setting plus one equals full periods edge mode, half periods center.
// - Input mode: capture register holds counter at latest capture event.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "tbc_defs.svh"

module tbc_top
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Channel signals
	input  wire logic        chan1_capture_in,
	input  wire logic        trig_reset_in,
	input  wire logic        chan1_compare_ref,
	output logic             chan1_compare_out,
	output logic             chan1_out_oe_n,
	// Time base status
	output logic             update_event,
	output logic      [15:0] counter_out,
	output logic             irq
);

	//**********************************************************
	// Reset and input synchronisers
	//**********************************************************

	logic       rst_meta_n;
	logic       rst_sync_n;
	logic [1:0] cap_sync;
	logic       cap_prev;
	logic [1:0] trig_sync;
	logic       trig_prev;

	// Release of reset is brought onto the clock by two stages.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// Pin inputs pass two stages; the edge detector reads only the second.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			cap_sync  <= 2'h0;
			cap_prev  <= 1'b0;
			trig_sync <= 2'h0;
			trig_prev <= 1'b0;
		end
		else
		begin
			cap_sync  <= {cap_sync[0], chan1_capture_in};
			cap_prev  <= cap_sync[1];
			trig_sync <= {trig_sync[0], trig_reset_in};
			trig_prev <= trig_sync[1];
		end
	end

	//**********************************************************
	// Register decode
	//**********************************************************

	logic            ctrl_run;
	logic            ctrl_in_mode;
	logic            ctrl_center;
	logic            ctrl_arpe;
	logic            chan1_enable;
	logic            chan1_compl_enable;
	logic            main_out_enable;
	logic            idle_off_state_sel;
	logic            run_off_state_sel;
	logic            chan1_idle_level;
	logic [1:0]      irq_mask;
	logic [1:0]      status;
	tbc_pkg::tbc_word_t prescaler_value;
	tbc_pkg::tbc_word_t prescaler_active;
	tbc_pkg::tbc_word_t prescaler_count;
	tbc_pkg::tbc_word_t auto_reload_value;
	tbc_pkg::tbc_word_t reload_active;
	tbc_pkg::tbc_word_t counter_value;
	tbc_pkg::tbc_word_t chan1_capture_compare_value;
	logic [7:0]      repetition_setting;
	logic [7:0]      repetition_downcounter;
	tbc_pkg::tbc_dir_t  count_dir;

	// Write strobe for one address. The strobe and address come in as
	// arguments so that every continuous assignment follows them.
	function automatic logic tbc_hit(input logic wr, input logic [7:0] a,
		input logic [7:0] ofs);
		tbc_hit = wr && (a == ofs);
	endfunction

	logic wr_ctrl;
	logic wr_mask;
	logic wr_status;
	logic wr_evgen;
	logic wr_chen;
	logic wr_cnt;
	logic wr_psc;
	logic wr_arr;
	logic wr_rep;
	logic wr_ccr;
	logic wr_out;

	assign wr_ctrl   = tbc_hit(reg_wr, reg_addr, `TBC_OFS_CTRL);
	assign wr_mask   = tbc_hit(reg_wr, reg_addr, `TBC_OFS_IRQ_MASK);
	assign wr_status = tbc_hit(reg_wr, reg_addr, `TBC_OFS_STATUS);
	assign wr_evgen  = tbc_hit(reg_wr, reg_addr, `TBC_OFS_EVGEN);
	assign wr_chen   = tbc_hit(reg_wr, reg_addr, `TBC_OFS_CHAN_EN);
	assign wr_cnt    = tbc_hit(reg_wr, reg_addr, `TBC_OFS_COUNTER);
	assign wr_psc    = tbc_hit(reg_wr, reg_addr, `TBC_OFS_PRESCALE);
	assign wr_arr    = tbc_hit(reg_wr, reg_addr, `TBC_OFS_RELOAD);
	assign wr_rep    = tbc_hit(reg_wr, reg_addr, `TBC_OFS_REPEAT);
	assign wr_ccr    = tbc_hit(reg_wr, reg_addr, `TBC_OFS_CAPTURE);
	assign wr_out    = tbc_hit(reg_wr, reg_addr, `TBC_OFS_OUT_CTRL);

	//**********************************************************
	// Configuration registers
	//**********************************************************

	// Plain software settings.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctrl_run           <= 1'b0;
			ctrl_in_mode       <= 1'b0;
			ctrl_center        <= 1'b0;
			ctrl_arpe          <= 1'b0;
			chan1_enable       <= 1'b0;
			chan1_compl_enable <= 1'b0;
			main_out_enable    <= 1'b0;
			idle_off_state_sel <= 1'b0;
			run_off_state_sel  <= 1'b0;
			chan1_idle_level   <= 1'b0;
			irq_mask           <= 2'h0;
			prescaler_value    <= `TBC_RST_ZERO16;
			auto_reload_value  <= `TBC_RST_RELOAD;
			repetition_setting <= `TBC_RST_ZERO8;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_run     <= reg_wdata[`TBC_CTRL_RUN];
				ctrl_in_mode <= reg_wdata[`TBC_CTRL_IN_MODE];
				ctrl_center  <= reg_wdata[`TBC_CTRL_CENTER];
				ctrl_arpe    <= reg_wdata[`TBC_CTRL_ARPE];
			end
			if (wr_chen)
			begin
				chan1_enable       <= reg_wdata[`TBC_CHEN_ENABLE];
				chan1_compl_enable <= reg_wdata[`TBC_CHEN_COMPL];
			end
			if (wr_out)
			begin
				main_out_enable    <= reg_wdata[`TBC_OUT_MAIN_EN];
				idle_off_state_sel <= reg_wdata[`TBC_OUT_IDLE_OSS];
				run_off_state_sel  <= reg_wdata[`TBC_OUT_RUN_OSS];
				chan1_idle_level   <= reg_wdata[`TBC_OUT_IDLE_LVL];
			end
			if (wr_mask)
				irq_mask <= reg_wdata[1:0];
			if (wr_psc)
				prescaler_value <= reg_wdata[15:0];
			if (wr_arr)
				auto_reload_value <= reg_wdata[15:0];
			if (wr_rep)
				repetition_setting <= reg_wdata[7:0];
		end
	end

	//**********************************************************
	// Prescaler and counter
	//**********************************************************

	logic tick;
	logic wrap;
	logic soft_update_generate;
	logic trig_clear;
	logic forced_update;
	logic repetition_update_event;
	logic any_update;
	logic capture_event;

	assign soft_update_generate = wr_evgen && reg_wdata[`TBC_EV_UPDATE];
	assign trig_clear    = trig_sync[1] && !trig_prev;
	assign forced_update = soft_update_generate || trig_clear;
	// A zero reload value holds the whole time base still.
	// zero reload stops
	assign tick = ctrl_run && (reload_active != 16'h0000)
		&& (prescaler_count == prescaler_active);

	// Prescaler divides by active setting plus one.
	// prescaler division
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			prescaler_count <= `TBC_RST_ZERO16;
		else if (forced_update || tick)
			prescaler_count <= 16'h0000;
		else if (ctrl_run && reload_active != 16'h0000)
			prescaler_count <= prescaler_count + 16'h0001;
	end

	// Wrap point: top in edge mode, either end in center mode.
	always_comb
	begin
		wrap = 1'b0;
		if (tick)
		begin
			if (!ctrl_center)
				wrap = (counter_value >= reload_active);
			else if (count_dir == tbc_pkg::TBC_DIR_UP)
				wrap = (counter_value >= reload_active);
			else
				wrap = (counter_value == 16'h0000);
		end
	end

	// Counter steps once per tick; software writes win over counting.
	// counter up and wrap
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			counter_value <= `TBC_RST_ZERO16;
			count_dir     <= tbc_pkg::TBC_DIR_UP;
		end
		else if (wr_cnt)
			counter_value <= reg_wdata[15:0];
		else if (forced_update)
		begin
			counter_value <= 16'h0000;
			count_dir     <= tbc_pkg::TBC_DIR_UP;
		end
		else if (tick)
		begin
			case (count_dir)
				tbc_pkg::TBC_DIR_UP:
				begin
					if (!wrap)
						counter_value <= counter_value + 16'h0001;
					else if (!ctrl_center)
						counter_value <= 16'h0000;
					else
					begin
						counter_value <= reload_active - 16'h0001;
						count_dir     <= tbc_pkg::TBC_DIR_DOWN;
					end
				end
				tbc_pkg::TBC_DIR_DOWN:
				begin
					if (!wrap)
						counter_value <= counter_value - 16'h0001;
					else
					begin
						counter_value <= 16'h0001;
						count_dir     <= tbc_pkg::TBC_DIR_UP;
					end
				end
				default:
				begin
					counter_value <= 16'h0000;
					count_dir     <= tbc_pkg::TBC_DIR_UP;
				end
			endcase
		end
	end

	//**********************************************************
	// Repetition and update
	//**********************************************************

	// Each wrap is one period in edge mode, one half period in center.
	// periods per update
	assign repetition_update_event = wrap
		&& (repetition_downcounter == 8'h00);
	assign any_update = repetition_update_event || forced_update;

	// Setting is only sampled on reload, so writes wait for the next update.
	// down-counter reload
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			repetition_downcounter <= `TBC_RST_ZERO8;
		else if (any_update)
			repetition_downcounter <= repetition_setting;
		else if (wrap)
			repetition_downcounter <= repetition_downcounter - 8'h01;
	end

	// Active copies load at update; reload bypasses when preload is off.
	// prescaler at update
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			prescaler_active <= `TBC_RST_ZERO16;
			reload_active    <= `TBC_RST_RELOAD;
		end
		else
		begin
			if (any_update)
				prescaler_active <= prescaler_value;
			if (!ctrl_arpe || any_update)
				reload_active <= auto_reload_value;
		end
	end

	//**********************************************************
	// Capture
	//**********************************************************

	assign capture_event = ctrl_in_mode && chan1_enable
		&& cap_sync[1] && !cap_prev;

	// Capture overwrites; in output mode software owns the value.
	// latest capture
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			chan1_capture_compare_value <= `TBC_RST_ZERO16;
		else if (capture_event)
			chan1_capture_compare_value <= counter_value;
		else if (wr_ccr && !ctrl_in_mode)
			chan1_capture_compare_value <= reg_wdata[15:0];
	end

	//**********************************************************
	// Status and interrupt
	//**********************************************************

	// A new event beats a same-cycle clear so none is lost.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			status <= 2'h0;
		else
			status <= (status & ~(wr_status ? reg_wdata[1:0] : 2'h0))
				| {capture_event, any_update};
	end

	// Interrupt and status outputs are registered.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			irq          <= 1'b0;
			update_event <= 1'b0;
			counter_out  <= 16'h0000;
		end
		else
		begin
			irq          <= |(status & irq_mask);
			update_event <= any_update;
			counter_out  <= counter_value;
		end
	end

	//**********************************************************
	// Channel output stage
	//**********************************************************

	// Off-state selects decide drive of the inactive or idle level
	// versus releasing the pin; the complementary leg lives elsewhere.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			chan1_compare_out <= 1'b0;
			chan1_out_oe_n    <= 1'b1;
		end
		else if (ctrl_in_mode)
		begin
			chan1_compare_out <= 1'b0;
			chan1_out_oe_n    <= 1'b1;
		end
		else if (!main_out_enable)
		begin
			chan1_compare_out <= chan1_idle_level;
			chan1_out_oe_n    <= !idle_off_state_sel;
		end
		else if (chan1_enable)
		begin
			chan1_compare_out <= chan1_compare_ref;
			chan1_out_oe_n    <= 1'b0;
		end
		else
		begin
			chan1_compare_out <= 1'b0;
			chan1_out_oe_n    <= !(run_off_state_sel
				|| chan1_compl_enable);
		end
	end

	//**********************************************************
	// Read port
	//**********************************************************

	// Read data appear the cycle after the strobe; others read zero.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			reg_rdata <= 32'h0000_0000;
		else if (!reg_rd)
			reg_rdata <= 32'h0000_0000;
		else
		begin
			case (reg_addr)
				`TBC_OFS_CTRL:
					reg_rdata <= {28'h0, ctrl_arpe, ctrl_center,
						ctrl_in_mode, ctrl_run};
				`TBC_OFS_IRQ_MASK: reg_rdata <= {30'h0, irq_mask};
				`TBC_OFS_STATUS:   reg_rdata <= {30'h0, status};
				`TBC_OFS_CHAN_EN:
					reg_rdata <= {29'h0, chan1_compl_enable, 1'b0,
						chan1_enable};
				`TBC_OFS_COUNTER:  reg_rdata <= {16'h0, counter_value};
				`TBC_OFS_PRESCALE: reg_rdata <= {16'h0, prescaler_value};
				`TBC_OFS_RELOAD:
					reg_rdata <= {16'h0, auto_reload_value};
				`TBC_OFS_REPEAT:
					reg_rdata <= {24'h0, repetition_setting};
				`TBC_OFS_CAPTURE:
					reg_rdata <= {16'h0, chan1_capture_compare_value};
				`TBC_OFS_OUT_CTRL:
					reg_rdata <= {16'h0, main_out_enable, 3'h0,
						run_off_state_sel, idle_off_state_sel, 1'b0,
						chan1_idle_level, 8'h00};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// [testbench/tbc_monitor.sv]
`timescale 1ns/10ps
`include "tbc_defs.svh"

// ************************************************************
// Port checker for the time base block
// ************************************************************
module tbc_monitor
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Channel and time base
	input wire logic        chan1_capture_in,
	input wire logic        trig_reset_in,
	input wire logic        chan1_compare_ref,
	input wire logic        chan1_compare_out,
	input wire logic        chan1_out_oe_n,
	input wire logic        update_event,
	input wire logic [15:0] counter_out,
	input wire logic        irq
);
	logic [31:0] ctrl_s;
	logic [31:0] chen_s;
	logic [31:0] outc_s;
	logic [1:0]  mask_s;
	logic        rl_zero;
	logic [7:0]  frz;
	logic        in_m;
	logic        main_on;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Shadows change at the same edge as the real registers do.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_s  <= 32'h00000000;
			chen_s  <= 32'h00000000;
			outc_s  <= 32'h00000000;
			mask_s  <= 2'h0;
			rl_zero <= 1'b0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`TBC_OFS_CTRL:     ctrl_s <= reg_wdata;
				`TBC_OFS_CHAN_EN:  chen_s <= reg_wdata;
				`TBC_OFS_OUT_CTRL: outc_s <= reg_wdata;
				`TBC_OFS_IRQ_MASK: mask_s <= reg_wdata[1:0];
				`TBC_OFS_RELOAD:   rl_zero <= (reg_wdata[15:0] == 16'h0000);
				default:           ;
			endcase
		end
	end

	// Quiet cycles under a zero reload; writes or a trigger may move
	// the counter, so they start the count again.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			frz <= 8'h00;
		else if (reg_wr || trig_reset_in || !rl_zero || ctrl_s[3])
			frz <= 8'h00;
		else if (frz != 8'hFF)
			frz <= frz + 8'h01;
	end

	// Decoded mode bits.
	assign in_m = ctrl_s[`TBC_CTRL_IN_MODE];
	assign main_on = outc_s[`TBC_OUT_MAIN_EN];

	rd_idle_a:
	assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
		else $error("Read data not zero outside a read answer.");
	rep_upper_a:
	assert property ($past(reg_rd) && $past(reg_addr) == `TBC_OFS_REPEAT
		|-> reg_rdata[31:8] == 24'h000000)
		else $error("Repetition read shows upper bits.");
	idle_out_a:
	assert property ($past(!in_m && !main_on) |->
		chan1_compare_out == $past(outc_s[`TBC_OUT_IDLE_LVL]) &&
		chan1_out_oe_n == !$past(outc_s[`TBC_OUT_IDLE_OSS]))
		else $error("Idle pin level wrong with main enable off.");
	en_off_a:
	assert property ($past(!in_m && main_on && !chen_s[0]) |->
		!chan1_compare_out && chan1_out_oe_n ==
		!$past(outc_s[`TBC_OUT_RUN_OSS] || chen_s[`TBC_CHEN_COMPL]))
		else $error("Disabled channel drives its compare signal.");
	en_on_a:
	assert property ($past(!in_m && main_on && chen_s[0]) |->
		chan1_compare_out == $past(chan1_compare_ref) && !chan1_out_oe_n)
		else $error("Enabled channel does not route compare signal.");
	input_pin_a:
	assert property ($past(in_m) |-> chan1_out_oe_n)
		else $error("Pin driven in input mode.");
	counter_frozen_a:
	assert property (frz >= 8'h06 |-> $stable(counter_out))
		else $error("Counter moves with zero reload.");
	counter_step_a:
	assert property (!ctrl_s[2] && !$past(ctrl_s[2]) && !$past(reg_wr)
		&& !$past(reg_wr, 2) |-> counter_out == $past(counter_out) ||
		counter_out == $past(counter_out) + 16'h0001 ||
		counter_out == 16'h0000)
		else $error("Counter stepped other than up by one or wrap.");
	irq_on_a:
	assert property (update_event && mask_s[0] |-> ##[0:2] irq)
		else $error("Masked-in update did not raise the interrupt.");
	irq_off_a:
	assert property ($past(mask_s) == 2'h0 |-> !irq)
		else $error("Interrupt high with all sources masked.");
endmodule

bind tbc_top tbc_monitor mon_u
(
	.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.chan1_capture_in, .trig_reset_in, .chan1_compare_ref,
	.chan1_compare_out, .chan1_out_oe_n, .update_event, .counter_out, .irq
);

// [testbench/tbc_top_tb.sv]
`timescale 1ns/10ps
`include "tbc_defs.svh"
`define CHK(n, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("BAD %s exp %0h got %0h", n, e, g); \
		end \
	end

// ************************************************************
// Bench for the time base block
// ************************************************************
module tbc_top_tb;
	logic        clk, rst_n, reg_wr, reg_rd, irq, update_event;
	logic        chan1_capture_in, trig_reset_in, chan1_compare_ref;
	logic        chan1_compare_out, chan1_out_oe_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] counter_out;
	int          err_total, comparisons, cyc;

	tbc_top dut_u
	(
		.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.chan1_capture_in, .trig_reset_in, .chan1_compare_ref,
		.chan1_compare_out, .chan1_out_oe_n, .update_event,
		.counter_out, .irq
	);

	// Clock and a free cycle count used to time update pulses.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	// Register port cycles.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Read data stand for this one cycle; look mid-cycle.
		@(negedge clk);
		`CHK(n, e, reg_rdata)
	endtask

	// Waits for the next update pulse; a hang is left to the watchdog.
	task sync(output int c);
		do @(posedge clk); while (update_event !== 1'b1);
		c = cyc;
	endtask

	// Stops, programs and restarts the time base with a soft update.
	task cfg(input logic [31:0] p, r, n, c);
		wr(`TBC_OFS_CTRL, 32'h0);
		wr(`TBC_OFS_PRESCALE, p);
		wr(`TBC_OFS_RELOAD, r);
		wr(`TBC_OFS_REPEAT, n);
		wr(`TBC_OFS_EVGEN, 32'h1);
		wr(`TBC_OFS_CTRL, c);
	endtask

	// The soft update pulse is over before this runs; the first update pulse after the restart is skipped.
	task chg(input logic [7:0] a, input logic [31:0] d, input int e1, e2);
		int t0, t1, t2;
		sync(t0);
		sync(t0);
		if (a != 8'h00)
			wr(a, d);
		sync(t1);
		`CHK("first gap", e1, t1 - t0)
		sync(t2);
		`CHK("next gap", e2, t2 - t1)
	endtask

	task pulse(input bit trig);
		@(posedge clk);
		if (trig)
			trig_reset_in <= 1'b1;
		else
			chan1_capture_in <= 1'b1;
		repeat (3) @(posedge clk);
		trig_reset_in <= 1'b0;
		chan1_capture_in <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task outchk(input logic [31:0] o, c, input logic eo, ee);
		wr(`TBC_OFS_OUT_CTRL, o);
		wr(`TBC_OFS_CHAN_EN, c);
		repeat (2) @(posedge clk);
		`CHK("pin level", eo, chan1_compare_out)
		`CHK("pin enable", ee, chan1_out_oe_n)
	endtask

	task tally_and_finish;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the expected run length.
	initial
	begin
		#(80000 * 8);
		err_total++;
		tally_and_finish();
	end

	// Main sequence.
	initial
	begin
		{rst_n, reg_wr, reg_rd, chan1_capture_in, trig_reset_in} = 5'h0;
		{chan1_compare_ref, reg_addr, reg_wdata} = 0;
		{err_total, comparisons} = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(`TBC_OFS_COUNTER, 32'h0, "counter");
		rdc(`TBC_OFS_PRESCALE, 32'h0, "prescaler");
		rdc(`TBC_OFS_RELOAD, 32'h0000FFFF, "reload");
		rdc(`TBC_OFS_REPEAT, 32'h0, "repetition");
		rdc(8'h48, 32'h0, "unmapped");
		wr(`TBC_OFS_COUNTER, 32'h1234);
		rdc(`TBC_OFS_COUNTER, 32'h1234, "counter");
		cfg(0, 2, 1, 1);
		chg(8'h00, 0, 6, 6);
		cfg(2, 3, 0, 1);
		chg(8'h00, 0, 12, 12);
		cfg(1, 4, 2, 1);
		chg(8'h00, 0, 30, 30);
		cfg(0, 4, 1, 5);
		chg(8'h00, 0, 8, 8);
		cfg(0, 9, 0, 1);
		chg(`TBC_OFS_PRESCALE, 1, 10, 20);
		cfg(0, 3, 0, 1);
		chg(`TBC_OFS_REPEAT, 2, 4, 12);
		cfg(0, 3, 0, 9);
		chg(`TBC_OFS_RELOAD, 7, 4, 8);
		wr(`TBC_OFS_CTRL, 32'h0);
		wr(`TBC_OFS_COUNTER, 32'h5);
		wr(`TBC_OFS_RELOAD, 32'h0);
		wr(`TBC_OFS_CTRL, 32'h1);
		repeat (10) @(posedge clk);
		rdc(`TBC_OFS_COUNTER, 32'h5, "frozen counter");
		`CHK("counter out", 16'h0005, counter_out)
		wr(`TBC_OFS_CTRL, 32'h2);
		wr(`TBC_OFS_COUNTER, 32'h77);
		wr(`TBC_OFS_STATUS, 32'h3);
		pulse(1'b0);
		rdc(`TBC_OFS_CAPTURE, 32'h0, "blocked capture");
		wr(`TBC_OFS_CHAN_EN, 32'h1);
		pulse(1'b0);
		rdc(`TBC_OFS_CAPTURE, 32'h77, "capture");
		rdc(`TBC_OFS_STATUS, 32'h2, "capture flag");
		wr(`TBC_OFS_CTRL, 32'h0);
		chan1_compare_ref <= 1'b1;
		outchk(32'h0500, 32'h1, 1'b1, 1'b0);
		outchk(32'h0100, 32'h1, 1'b1, 1'b1);
		outchk(32'h8000, 32'h0, 1'b0, 1'b1);
		outchk(32'h8800, 32'h0, 1'b0, 1'b0);
		outchk(32'h8000, 32'h4, 1'b0, 1'b0);
		outchk(32'h8000, 32'h1, 1'b1, 1'b0);
		chan1_compare_ref <= 1'b0;
		outchk(32'h8000, 32'h1, 1'b0, 1'b0);
		wr(`TBC_OFS_STATUS, 32'h3);
		wr(`TBC_OFS_IRQ_MASK, 32'h1);
		wr(`TBC_OFS_EVGEN, 32'h1);
		repeat (3) @(posedge clk);
		`CHK("irq raised", 1'b1, irq)
		wr(`TBC_OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		wr(`TBC_OFS_IRQ_MASK, 32'h1);
		wr(`TBC_OFS_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		wr(`TBC_OFS_RELOAD, 32'hFF);
		wr(`TBC_OFS_COUNTER, 32'h50);
		pulse(1'b1);
		rdc(`TBC_OFS_COUNTER, 32'h0, "trigger clear");
		rdc(`TBC_OFS_STATUS, 32'h1, "trigger update");
		tally_and_finish();
	end
endmodule
